// File: rtl/rrts_map.vh
`ifndef RRTS_MAP_VH
`define RRTS_MAP_VH
// ==========================================
// Sizes
`define RRTS_NTASK 4
`define RRTS_TW 2
`define RRTS_PCW 12
`define RRTS_SDEP 4
`define RRTS_SIW 2
`define RRTS_SCW 3
`define RRTS_DLW 16
// ==========================================
// Timing
`define RRTS_CLK_HZ 25000000
`define RRTS_MS_PER_S 1000
`define RRTS_MS_CYC (`RRTS_CLK_HZ / `RRTS_MS_PER_S)
`define RRTS_MSW 15
// ==========================================
// Values
`define RRTS_TOP_PC 12'h000
`define RRTS_LAST_TASK 2'h3
`define RRTS_CNT_SINGLE 3'h1
`define RRTS_OP_SUSP 2'h1
`define RRTS_OP_RES 2'h2
`define RRTS_OP_RST 2'h3
`define RRTS_RAM_LO_MAX 8'h7f
`define RRTS_RAM_HI_MAX 8'hff
`define RRTS_FREQ_4M 2'h0
`define RRTS_FREQ_FAST 2'h2
`define RRTS_CAL_ONE 3'h1
`endif

// File: rtl/rrts_stack.v
`timescale 1ns/100ps
`include "rrts_map.vh"
module rrts_stack (
	input wire clock,
	input wire rst_n,
	input wire clr,
	input wire push,
	input wire pop,
	input wire [`RRTS_PCW-1:0] push_pc,
	output wire [`RRTS_PCW-1:0] top_pc
);
	reg [`RRTS_PCW-1:0] mem_r [0:`RRTS_SDEP-1];
	reg [`RRTS_SCW-1:0] depth_r;
	wire [`RRTS_SIW-1:0] top_idx;
	integer i;

	assign top_idx = depth_r[`RRTS_SIW-1:0] - {{(`RRTS_SIW-1){1'b0}}, 1'b1};
	assign top_pc = (depth_r == {`RRTS_SCW{1'b0}}) ? `RRTS_TOP_PC : mem_r[top_idx];

	// ==========================================
	// Return stack, overflow drops the push, underflow returns program top
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			depth_r <= {`RRTS_SCW{1'b0}};
			for (i = 0; i < `RRTS_SDEP; i = i + 1) begin
				mem_r[i] <= `RRTS_TOP_PC;
			end
		end else if (clr) begin
			depth_r <= {`RRTS_SCW{1'b0}};
		end else if (push && depth_r != `RRTS_SDEP) begin
			mem_r[depth_r[`RRTS_SIW-1:0]] <= push_pc;
			depth_r <= depth_r + {{(`RRTS_SCW-1){1'b0}}, 1'b1};
		end else if (pop && depth_r != {`RRTS_SCW{1'b0}}) begin
			depth_r <= depth_r - {{(`RRTS_SCW-1){1'b0}}, 1'b1};
		end
	end
endmodule

// File: rtl/rrts_delay.v
`timescale 1ns/100ps
`include "rrts_map.vh"
module rrts_delay (
	input wire clock,
	input wire rst_n,
	input wire tick,
	input wire clr,
	input wire load,
	input wire [`RRTS_DLW-1:0] load_ms,
	output wire busy
);
	reg [`RRTS_DLW-1:0] left_r;

	assign busy = (left_r != {`RRTS_DLW{1'b0}});

	// ==========================================
	// Millisecond countdown of one task's pause
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_r <= {`RRTS_DLW{1'b0}};
		end else if (clr) begin
			left_r <= {`RRTS_DLW{1'b0}};
		end else if (load) begin
			left_r <= load_ms;
		end else if (tick && busy) begin
			left_r <= left_r - {{(`RRTS_DLW-1){1'b0}}, 1'b1};
		end
	end
endmodule

// File: rtl/rrts_sched.v
`timescale 1ns/100ps
`include "rrts_map.vh"
// Notes on behaviour
// - Commands taken one per task, cyclically
// - Tasks in a delay are skipped
// - Every task starts after any reset
// - Task 0 starts at program top, first
// - Own program counter and stack per task
// - One shared data space for all tasks
// - One interrupt halts every running task
// - Suspend disables a task, resume re-enables
// - Task index output updated each switch
// - Restart resets one task, nothing else
// - All suspended means no command issued
// - Sleep stops the core for all tasks
// - Blocking commands freeze task rotation
// - Multi mode ignores frequency command, core picks
// - Multi mode keeps timing at 4MHz calibration
// - Low-RAM multi mode reserves bytes 128-255
// - Byte pointer wraps at 127 or 255
// - Several entry points select multi-task mode
module rrts_sched #(
	parameter MS_CYC = `RRTS_MS_CYC
) (
	input wire clock,
	input wire rst_n,
	input wire [2:0] task_cnt,
	input wire [`RRTS_NTASK*`RRTS_PCW-1:0] entry_pcs,
	input wire low_ram,
	input wire cmd_done,
	input wire [`RRTS_PCW-1:0] cmd_npc,
	input wire cmd_call,
	input wire cmd_ret,
	input wire cmd_delay,
	input wire [`RRTS_DLW-1:0] cmd_dly_ms,
	input wire cmd_sleep,
	input wire wake,
	input wire blk_busy,
	input wire irq_req,
	input wire irq_done,
	input wire ctl_valid,
	input wire [1:0] ctl_op,
	input wire [`RRTS_TW-1:0] ctl_task,
	input wire freq_valid,
	input wire [1:0] freq_val,
	input wire ram_req,
	input wire [7:0] ram_addr,
	input wire bptr_set,
	input wire [7:0] bptr_val,
	input wire bptr_inc,
	output reg grant_r,
	output reg [`RRTS_TW-1:0] cur_task_r,
	output reg [`RRTS_PCW-1:0] cur_pc_r,
	output reg multi_r,
	output reg halt_r,
	output reg core_off_r,
	output reg irq_act_r,
	output reg [1:0] freq_sel_r,
	output reg [2:0] cal_pre_r,
	output reg ram_en_r,
	output reg ram_err_r,
	output reg [7:0] ram_addr_r,
	output reg [7:0] bptr_r
);
	localparam ST_LOAD = 2'h0;
	localparam ST_PICK = 2'h1;
	localparam ST_WAIT = 2'h2;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg first_r;
	reg [`RRTS_NTASK-1:0] present_r;
	reg [`RRTS_NTASK-1:0] susp_r;
	reg [`RRTS_NTASK*`RRTS_PCW-1:0] pc_r;
	reg [`RRTS_NTASK*`RRTS_PCW-1:0] entry_r;
	reg [`RRTS_MSW-1:0] ms_cnt_r;
	reg ms_tick_r;
	wire [`RRTS_NTASK-1:0] dly_busy;
	wire [`RRTS_NTASK*`RRTS_PCW-1:0] stk_top;
	wire [`RRTS_NTASK-1:0] elig;
	wire [`RRTS_TW-1:0] next_task;
	wire any_elig;
	wire hold;
	wire ctl_rst;
	wire ctl_susp;
	wire ctl_res;
	wire ret_pc_sel;
	wire [7:0] ram_max;
	wire [7:0] bptr_max;

	// ==========================================
	// Helpers
	function [`RRTS_NTASK-1:0] task_bit;
		input [`RRTS_TW-1:0] t;
		begin
			task_bit = {{(`RRTS_NTASK-1){1'b0}}, 1'b1} << t;
		end
	endfunction

	function [`RRTS_TW-1:0] rot_next;
		input [`RRTS_TW-1:0] cur;
		input [`RRTS_NTASK-1:0] mask;
		integer k;
		reg found;
		reg [`RRTS_TW-1:0] idx;
		begin
			found = 1'b0;
			rot_next = cur;
			idx = cur;
			for (k = 1; k <= `RRTS_NTASK; k = k + 1) begin
				idx = idx + {{(`RRTS_TW-1){1'b0}}, 1'b1};
				if (!found && mask[idx]) begin
					rot_next = idx;
					found = 1'b1;
				end
			end
		end
	endfunction

	assign ctl_rst = ctl_valid && (ctl_op == `RRTS_OP_RST);
	assign ctl_susp = ctl_valid && (ctl_op == `RRTS_OP_SUSP);
	assign ctl_res = ctl_valid && (ctl_op == `RRTS_OP_RES);
	assign ret_pc_sel = cmd_ret && !cmd_call;

	// ==========================================
	// Millisecond enable for pause countdowns
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_r <= {`RRTS_MSW{1'b0}};
			ms_tick_r <= 1'b0;
		end else if (ms_cnt_r == MS_CYC - 1) begin
			ms_cnt_r <= {`RRTS_MSW{1'b0}};
			ms_tick_r <= 1'b1;
		end else begin
			ms_cnt_r <= ms_cnt_r + {{(`RRTS_MSW-1){1'b0}}, 1'b1};
			ms_tick_r <= 1'b0;
		end
	end

	// ==========================================
	// Per-task stack and pause counter
	genvar g;
	generate
		for (g = 0; g < `RRTS_NTASK; g = g + 1) begin : g_task
			wire mine;
			wire clr;
			assign mine = cmd_done && (state_r == ST_WAIT) && (cur_task_r == g);
			assign clr = (state_r == ST_LOAD) || (ctl_rst && ctl_task == g);
			rrts_stack u_stack (
				.clock(clock),
				.rst_n(rst_n),
				.clr(clr),
				.push(mine && cmd_call),
				.pop(mine && ret_pc_sel),
				.push_pc(cur_pc_r + {{(`RRTS_PCW-1){1'b0}}, 1'b1}),
				.top_pc(stk_top[g*`RRTS_PCW +: `RRTS_PCW])
			);
			rrts_delay u_delay (
				.clock(clock),
				.rst_n(rst_n),
				.tick(ms_tick_r),
				.clr(clr),
				.load(mine && cmd_delay),
				.load_ms(cmd_dly_ms),
				.busy(dly_busy[g])
			);
		end
	endgenerate

	// ==========================================
	// Eligibility and rotation
	assign elig = present_r & ~susp_r & ~dly_busy;
	assign next_task = (first_r && elig[0]) ? {`RRTS_TW{1'b0}} : rot_next(cur_task_r, elig);
	assign any_elig = |elig;
	assign hold = core_off_r || irq_act_r || irq_req || blk_busy;

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_LOAD: begin
				state_nxt = ST_PICK;
			end
			ST_PICK: begin
				if (!hold && any_elig) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cmd_done) begin
					state_nxt = ST_PICK;
				end
			end
			default: begin
				state_nxt = ST_LOAD;
			end
		endcase
	end

	// ==========================================
	// Scheduler state, mode capture, grant
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_LOAD;
			first_r <= 1'b1;
			present_r <= {`RRTS_NTASK{1'b0}};
			multi_r <= 1'b0;
			entry_r <= {`RRTS_NTASK*`RRTS_PCW{1'b0}};
			grant_r <= 1'b0;
			cur_task_r <= {`RRTS_TW{1'b0}};
			cur_pc_r <= `RRTS_TOP_PC;
			halt_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			grant_r <= 1'b0;
			if (state_r == ST_LOAD) begin
				multi_r <= (task_cnt > `RRTS_CNT_SINGLE);
				entry_r <= {entry_pcs[`RRTS_NTASK*`RRTS_PCW-1:`RRTS_PCW], `RRTS_TOP_PC};
				if (task_cnt > `RRTS_CNT_SINGLE) begin
					present_r <= ~({`RRTS_NTASK{1'b1}} << task_cnt);
				end else begin
					present_r <= {{(`RRTS_NTASK-1){1'b0}}, 1'b1};
				end
			end
			if (state_r == ST_PICK) begin
				halt_r <= !any_elig;
				if (!hold && any_elig) begin
					first_r <= 1'b0;
					grant_r <= 1'b1;
					cur_task_r <= next_task;
					cur_pc_r <= pc_r[next_task*`RRTS_PCW +: `RRTS_PCW];
				end
			end
		end
	end

	// ==========================================
	// Program counters, suspend, resume, restart
	integer t;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= {`RRTS_NTASK*`RRTS_PCW{1'b0}};
			susp_r <= {`RRTS_NTASK{1'b0}};
		end else if (state_r == ST_LOAD) begin
			pc_r <= {entry_pcs[`RRTS_NTASK*`RRTS_PCW-1:`RRTS_PCW], `RRTS_TOP_PC};
			susp_r <= {`RRTS_NTASK{1'b0}};
		end else begin
			for (t = 0; t < `RRTS_NTASK; t = t + 1) begin
				if (ctl_rst && ctl_task == t) begin
					pc_r[t*`RRTS_PCW +: `RRTS_PCW] <= entry_r[t*`RRTS_PCW +: `RRTS_PCW];
				end else if (cmd_done && state_r == ST_WAIT && cur_task_r == t) begin
					if (ret_pc_sel) begin
						pc_r[t*`RRTS_PCW +: `RRTS_PCW] <= stk_top[t*`RRTS_PCW +: `RRTS_PCW];
					end else begin
						pc_r[t*`RRTS_PCW +: `RRTS_PCW] <= cmd_npc;
					end
				end
			end
			if (ctl_susp) begin
				susp_r <= susp_r | task_bit(ctl_task);
			end else if (ctl_res || ctl_rst) begin
				susp_r <= susp_r & ~task_bit(ctl_task);
			end
		end
	end

	// ==========================================
	// Sleep and the single interrupt
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_off_r <= 1'b0;
			irq_act_r <= 1'b0;
		end else begin
			if (cmd_done && cmd_sleep && state_r == ST_WAIT) begin
				core_off_r <= 1'b1;
			end else if (wake) begin
				core_off_r <= 1'b0;
			end
			if (state_r == ST_PICK && irq_req && !core_off_r && !blk_busy) begin
				irq_act_r <= 1'b1;
			end else if (irq_done) begin
				irq_act_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// Core frequency and peripheral calibration
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			freq_sel_r <= `RRTS_FREQ_4M;
			cal_pre_r <= `RRTS_CAL_ONE;
		end else if (multi_r) begin
			freq_sel_r <= `RRTS_FREQ_FAST;
			cal_pre_r <= `RRTS_CAL_ONE << `RRTS_FREQ_FAST;
		end else begin
			if (freq_valid) begin
				freq_sel_r <= freq_val;
			end
			cal_pre_r <= `RRTS_CAL_ONE;
		end
	end

	// ==========================================
	// Shared data space and byte pointer
	assign ram_max = (multi_r && low_ram) ? `RRTS_RAM_LO_MAX : `RRTS_RAM_HI_MAX;
	assign bptr_max = ram_max;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ram_en_r <= 1'b0;
			ram_err_r <= 1'b0;
			ram_addr_r <= 8'h00;
			bptr_r <= 8'h00;
		end else begin
			ram_en_r <= ram_req && (ram_addr <= ram_max);
			ram_err_r <= ram_req && (ram_addr > ram_max);
			if (ram_req) begin
				ram_addr_r <= ram_addr;
			end
			if (bptr_set) begin
				bptr_r <= bptr_val & bptr_max;
			end else if (bptr_inc) begin
				if (bptr_r >= bptr_max) begin
					bptr_r <= 8'h00;
				end else begin
					bptr_r <= bptr_r + 8'h01;
				end
			end
		end
	end
endmodule

// File: sim/rrts_sched_properties.sv
`timescale 1ns/100ps
// ==========================================
// Port checker
module rrts_props (
	input wire clock,
	input wire rst_n,
	input wire low_ram,
	input wire blk_busy,
	input wire ram_req,
	input wire [7:0] ram_addr,
	input wire bptr_set,
	input wire bptr_inc,
	input wire grant_r,
	input wire [1:0] cur_task_r,
	input wire multi_r,
	input wire halt_r,
	input wire core_off_r,
	input wire irq_act_r,
	input wire [1:0] freq_sel_r,
	input wire [2:0] cal_pre_r,
	input wire ram_en_r,
	input wire ram_err_r,
	input wire [7:0] bptr_r
);
	wire hi_addr = multi_r && low_ram && (ram_addr > 8'h7f);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	grant_pulse_a: assert property (grant_r |=> !grant_r) else $error("grant wider than one cycle");
	sleep_hold_a: assert property (core_off_r |-> !grant_r) else $error("grant while core off");
	irq_hold_a: assert property (irq_act_r |-> !grant_r) else $error("grant during interrupt");
	block_hold_a: assert property (blk_busy |=> !grant_r) else $error("grant while blocked");
	halt_hold_a: assert property (halt_r |-> !grant_r) else $error("grant while halted");
	single_task_a: assert property (!multi_r |-> cur_task_r == 2'h0) else $error("task moved off zero");
	ram_high_a: assert property (ram_req && hi_addr |=> ram_err_r && !ram_en_r) else $error("reserved byte taken");
	ram_low_a: assert property (ram_req && !hi_addr |=> ram_en_r && !ram_err_r) else $error("user byte refused");
	bptr_wrap_a: assert property (multi_r && low_ram && bptr_inc && !bptr_set && bptr_r == 8'h7f |=> bptr_r == 8'h00)
		else $error("pointer did not wrap at 7f");
	mode_cal_a: assert property (multi_r && $past(multi_r) |-> cal_pre_r == 3'h4 && freq_sel_r == 2'h2)
		else $error("multi mode timing wrong");
endmodule
bind rrts_sched rrts_props i_rrts_props (.clock(clock), .rst_n(rst_n), .low_ram(low_ram), .blk_busy(blk_busy),
	.ram_req(ram_req), .ram_addr(ram_addr), .bptr_set(bptr_set), .bptr_inc(bptr_inc), .grant_r(grant_r),
	.cur_task_r(cur_task_r), .multi_r(multi_r), .halt_r(halt_r), .core_off_r(core_off_r), .irq_act_r(irq_act_r),
	.freq_sel_r(freq_sel_r), .cal_pre_r(cal_pre_r), .ram_en_r(ram_en_r), .ram_err_r(ram_err_r), .bptr_r(bptr_r));

// File: sim/rrts_sched_tb.sv
`timescale 1ns/100ps
module rrts_sched_tb;
	reg clock, rst_n, low_ram, cmd_done, cmd_call, cmd_ret, cmd_delay, cmd_sleep, wake, blk_busy, irq_req, irq_done;
	reg ctl_valid, freq_valid, ram_req, bptr_set, bptr_inc;
	reg [2:0] task_cnt;
	reg [47:0] entry_pcs;
	reg [11:0] cmd_npc;
	reg [15:0] cmd_dly_ms;
	reg [1:0] ctl_op, ctl_task, freq_val;
	reg [7:0] ram_addr, bptr_val;
	wire grant_r, multi_r, halt_r, core_off_r, irq_act_r, ram_en_r, ram_err_r;
	wire [1:0] cur_task_r, freq_sel_r;
	wire [11:0] cur_pc_r;
	wire [2:0] cal_pre_r;
	wire [7:0] ram_addr_r, bptr_r;
	integer err_count, n_checks, seed, i, n_grant, n_used;
	reg [31:0] rv;
	reg [11:0] pcm [0:3];
	reg [11:0] stk [0:3];
	rrts_sched #(.MS_CYC(10)) i_rrts_sched (.clock(clock), .rst_n(rst_n), .task_cnt(task_cnt), .entry_pcs(entry_pcs),
		.low_ram(low_ram), .cmd_done(cmd_done), .cmd_npc(cmd_npc), .cmd_call(cmd_call), .cmd_ret(cmd_ret),
		.cmd_delay(cmd_delay), .cmd_dly_ms(cmd_dly_ms), .cmd_sleep(cmd_sleep), .wake(wake), .blk_busy(blk_busy),
		.irq_req(irq_req), .irq_done(irq_done), .ctl_valid(ctl_valid), .ctl_op(ctl_op), .ctl_task(ctl_task),
		.freq_valid(freq_valid), .freq_val(freq_val), .ram_req(ram_req), .ram_addr(ram_addr), .bptr_set(bptr_set),
		.bptr_val(bptr_val), .bptr_inc(bptr_inc), .grant_r(grant_r), .cur_task_r(cur_task_r), .cur_pc_r(cur_pc_r),
		.multi_r(multi_r), .halt_r(halt_r), .core_off_r(core_off_r), .irq_act_r(irq_act_r), .freq_sel_r(freq_sel_r),
		.cal_pre_r(cal_pre_r), .ram_en_r(ram_en_r), .ram_err_r(ram_err_r), .ram_addr_r(ram_addr_r), .bptr_r(bptr_r));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Counts grants, so one issued while the bench was busy elsewhere is not lost
	always @(negedge clock) begin
		if (grant_r === 1'b1)
			n_grant = n_grant + 1;
	end
	// ==========================================
	// Helpers
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// Pointer after a masked load and one increment, wrapping at the active limit
	function [7:0] bptr_exp(input [7:0] bp, input m);
		reg [7:0] lim;
		begin
			lim = m ? 8'h7f : 8'hff;
			bptr_exp = ((bp & lim) == lim) ? 8'h00 : (bp & lim) + 8'h01;
		end
	endfunction
	task start(input [2:0] n);
		integer t;
		begin
			@(posedge clock);
			rst_n <= 1'b0;
			task_cnt <= n;
			rv = $random(seed);
			entry_pcs <= {rv, 16'h0000};
			repeat (2) @(posedge clock);
			rst_n <= 1'b1;
			#1;
			for (t = 0; t < 4; t = t + 1) begin
				pcm[t] = entry_pcs[t*12+:12];
				stk[t] = 12'h000;
			end
			pcm[0] = 12'h000;
			n_used = n_grant;
		end
	endtask
	// Waits for one grant, checks task and pc, then finishes the command
	task run(input [1:0] et, input c, input r, input d, input s);
		integer k;
		begin
			k = 0;
			while (n_grant == n_used && k < 200) begin
				@(negedge clock);
				#1;
				k = k + 1;
			end
			n_used = n_grant;
			chk(k < 200, 1);
			chk(cur_task_r, et);
			chk(cur_pc_r, pcm[et]);
			rv = $random(seed);
			@(posedge clock);
			{cmd_done, cmd_call, cmd_ret, cmd_delay, cmd_sleep} <= {1'b1, c, r, d, s};
			cmd_npc <= rv[11:0];
			@(posedge clock);
			cmd_done <= 1'b0;
			if (c) begin
				stk[et] = pcm[et] + 12'h001;
				pcm[et] = cmd_npc;
			end else if (r)
				pcm[et] = stk[et];
			else
				pcm[et] = cmd_npc;
		end
	endtask
	task ctl(input [1:0] op, input [1:0] t);
		begin
			@(posedge clock);
			{ctl_valid, ctl_op, ctl_task} <= {1'b1, op, t};
			@(posedge clock);
			ctl_valid <= 1'b0;
			if (op == 2'h3) begin
				pcm[t] = entry_pcs[t*12+:12];
				stk[t] = 12'h000;
			end
		end
	endtask
	task pulse_chk(input [7:0] a, input [7:0] bp, input [1:0] fv, input m);
		begin
			@(posedge clock);
			{ram_req, ram_addr, bptr_set, bptr_val, freq_valid, freq_val} <= {1'b1, a, 1'b1, bp, 1'b1, fv};
			@(posedge clock);
			{ram_req, bptr_set, freq_valid, bptr_inc} <= 4'h1;
			#1;
			chk(ram_err_r, m && a > 8'h7f);
			chk(ram_en_r, !(m && a > 8'h7f));
			chk(ram_addr_r, a);
			@(posedge clock);
			bptr_inc <= 1'b0;
			#1;
			chk(bptr_r, bptr_exp(bp, m));
			chk({freq_sel_r, cal_pre_r}, m ? 5'h14 : {fv, 3'h1});
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		err_count = 0;
		n_checks = 0;
		n_grant = 0;
		n_used = 0;
		seed = 63;
		{rst_n, low_ram, cmd_done, cmd_call, cmd_ret, cmd_delay, cmd_sleep, wake, blk_busy, irq_req} = 10'h100;
		{irq_done, ctl_valid, freq_valid, ram_req, bptr_set, bptr_inc, task_cnt, ctl_op, ctl_task, freq_val} = 0;
		{entry_pcs, cmd_npc, cmd_dly_ms, ram_addr, bptr_val} = 0;
		cmd_dly_ms = 16'h0005;
		start(3'h1);
		for (i = 0; i < 3; i = i + 1)
			run(2'h0, i == 0, i == 1, 1'b0, 1'b0);
		chk(multi_r, 0);
		pulse_chk(8'hc0, 8'hff, 2'h2, 1'b0);
		start(3'h4);
		for (i = 0; i < 8; i = i + 1)
			run(i % 4, i == 1, i == 5, 1'b0, 1'b0);
		chk(multi_r, 1);
		for (i = 0; i < 8; i = i + 1) begin
			rv = $random(seed);
			pulse_chk(i == 0 ? 8'h7f : i == 1 ? 8'h80 : rv[7:0], i < 2 ? 8'h7f : rv[15:8], 2'h0, 1'b1);
		end
		ctl(2'h1, 2'h2);
		run(2'h0, 0, 0, 0, 0);
		run(2'h1, 0, 0, 0, 0);
		run(2'h3, 0, 0, 0, 0);
		ctl(2'h2, 2'h2);
		run(2'h0, 0, 0, 0, 0);
		run(2'h1, 0, 0, 1, 0);
		for (i = 0; i < 6; i = i + 1)
			run(2 + (i % 3 == 2 ? 2 : i % 3), 0, 0, 0, 0);
		ctl(2'h3, 2'h1);
		run(2'h2, 0, 0, 0, 0);
		run(2'h3, 0, 0, 0, 0);
		run(2'h0, 0, 0, 0, 1);
		repeat (6) @(posedge clock);
		#1;
		chk(core_off_r, 1);
		@(posedge clock);
		wake <= 1'b1;
		blk_busy <= 1'b1;
		@(posedge clock);
		wake <= 1'b0;
		repeat (8) @(posedge clock);
		blk_busy <= 1'b0;
		irq_req <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		chk(irq_act_r, 1);
		@(posedge clock);
		{irq_req, irq_done} <= 2'h1;
		@(posedge clock);
		irq_done <= 1'b0;
		#1;
		chk(irq_act_r, 0);
		chk(n_grant - n_used, 0);
		run(2'h1, 0, 0, 0, 0);
		for (i = 0; i < 4; i = i + 1)
			ctl(2'h1, i);
		run(2'h2, 0, 0, 0, 0);
		repeat (8) @(posedge clock);
		#1;
		chk({halt_r, grant_r}, 2'h2);
		start(3'h2);
		run(2'h0, 0, 0, 0, 0);
		run(2'h1, 0, 0, 0, 0);
		conclude;
	end
	initial begin
		#400000;
		err_count = err_count + 1;
		conclude;
	end
endmodule
